// >>> rtl/rsim_pkg.sv
`default_nettype none
package rsim_pkg;
   // register offsets
   localparam logic [6:0] RSIM_ADDR_MODE_HI = 7'h0D;
   localparam logic [6:0] RSIM_ADDR_MODE_LO = 7'h0E;
   localparam logic [6:0] RSIM_ADDR_CHSTAT  = 7'h0F;
   localparam logic [6:0] RSIM_ADDR_RXERR   = 7'h10;
   localparam logic [6:0] RSIM_ADDR_IRQ2ST  = 7'h08;
   localparam logic [6:0] RSIM_ADDR_IRQ2MK  = 7'h0C;
   localparam logic [6:0] RSIM_ADDR_RXERMK  = 7'h11;
   localparam logic [6:0] RSIM_ADDR_CSCTL   = 7'h12;
   // reset values
   localparam logic [7:0] RSIM_MODE_RST     = 8'h00;
   localparam logic [7:0] RSIM_MASK_RST     = 8'h00;
   localparam logic [7:0] RSIM_CSCTL_RST    = 8'h00;
   // layout
   localparam int         RSIM_NSRC         = 6;
   localparam logic [5:0] RSIM_MODE_MASK    = 6'h3F;
   localparam logic [6:0] RSIM_RXERR_MASK   = 7'h7F;
   localparam int         RSIM_CHAN_SEL_BIT = 0;
   // trigger codes
   typedef enum logic [1:0] {
      RSIM_TRIG_RISE  = 2'h0,
      RSIM_TRIG_FALL  = 2'h1,
      RSIM_TRIG_LEVEL = 2'h2,
      RSIM_TRIG_RSVD  = 2'h3
   } rsim_trig_t;
   // decoded channel status of one channel
   typedef struct packed {
      logic [3:0] aux_len;
      logic       pro;
      logic       audio_n;
      logic       copy_n;
      logic       gen_bit;
      logic [7:0] category;
   } rsim_chan_t;
   // register access port
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } rsim_req_t;
endpackage
`default_nettype wire

// >>> rtl/rsim_regs.sv
`default_nettype none
// Contract
// - each irq2 source gets a 2-bit trigger code from the two mode regs.
// - code high bit lives at 0Dh, low bit at 0Eh, same bit position.
// - 00 rising, 01 falling, 10 level, 11 reserved and not used by host.
// - interrupt on rise, on fall, or while present, per the code.
// - both mode registers reset to 00, all sources rising-edge.
// - 0Fh is read-only decoded channel status; writes do nothing.
// - 10h is read-only receiver error flags; writes do nothing.
// - masked receiver errors never reach the error register or pins.
// - channel select 1 shows channel B status, 0 shows channel A.
// - reading 08h clears it except sources that trigger in the read cycle, live level or edge; reading 10h keeps live unmasked errors.
module rsim_regs
   import rsim_pkg::*;
(
   input  wire logic                     core_clk,
   input  wire logic                     resetn,
   input  wire rsim_req_t                req,
   output logic [7:0]                    rdata,
   input  wire logic [RSIM_NSRC-1:0]     irq2_src,
   input  wire rsim_chan_t               chan_a,
   input  wire rsim_chan_t               chan_b,
   input  wire logic [6:0]               rx_err_src,
   output logic                          int_out,
   output logic                          rx_err_out,
   output logic                          emphasis_pin
);
   // ****************************************
   // control registers
   // ****************************************
   logic [5:0] mode_hi_r;
   logic [5:0] mode_lo_r;
   logic [5:0] irq2_mask_r;
   logic [6:0] rxerr_mask_r;
   logic [7:0] csctl_r;
   logic [7:0] rdata_r;
   logic [6:0] rxerr_r;
   logic       wr_hi;
   logic       wr_lo;
   logic       wr_mk;
   logic       wr_em;
   logic       wr_cs;
   logic       rd_irq2;
   logic       rd_err;
   assign wr_hi   = req.wr && (req.addr == RSIM_ADDR_MODE_HI);
   assign wr_lo   = req.wr && (req.addr == RSIM_ADDR_MODE_LO);
   assign wr_mk   = req.wr && (req.addr == RSIM_ADDR_IRQ2MK);
   assign wr_em   = req.wr && (req.addr == RSIM_ADDR_RXERMK);
   assign wr_cs   = req.wr && (req.addr == RSIM_ADDR_CSCTL);
   assign rd_irq2 = req.rd && (req.addr == RSIM_ADDR_IRQ2ST);
   assign rd_err  = req.rd && (req.addr == RSIM_ADDR_RXERR);
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         mode_hi_r    <= RSIM_MODE_RST[5:0];
         mode_lo_r    <= RSIM_MODE_RST[5:0];
         irq2_mask_r  <= RSIM_MASK_RST[5:0];
         rxerr_mask_r <= RSIM_MASK_RST[6:0];
         csctl_r      <= RSIM_CSCTL_RST;
      end else begin
         if (wr_hi)
            mode_hi_r <= req.wdata[5:0] & RSIM_MODE_MASK;
         if (wr_lo)
            mode_lo_r <= req.wdata[5:0] & RSIM_MODE_MASK;
         if (wr_mk)
            irq2_mask_r <= req.wdata[5:0];
         if (wr_em)
            rxerr_mask_r <= req.wdata[6:0] & RSIM_RXERR_MASK;
         if (wr_cs)
            csctl_r <= {2'h0, req.wdata[5:0]};
      end
   end
   // ****************************************
   // interrupt 2 sources
   // ****************************************
   logic [RSIM_NSRC-1:0] irq2_flag;
   genvar gi;
   generate
      for (gi = 0; gi < RSIM_NSRC; gi++) begin : g_src
         rsim_trig u_trig (
            .core_clk (core_clk),
            .resetn   (resetn),
            .src      (irq2_src[gi]),
            .code     ({mode_hi_r[gi], mode_lo_r[gi]}),
            .enable   (irq2_mask_r[gi]),
            .clr      (rd_irq2),
            .flag     (irq2_flag[gi])
         );
      end
   endgenerate
   assign int_out = |irq2_flag;
   // ****************************************
   // receiver channel status
   // ****************************************
   rsim_chan_t ch_sel;
   logic       gen_flag;
   logic [7:0] chstat;
   assign ch_sel = csctl_r[RSIM_CHAN_SEL_BIT] ? chan_b : chan_a;
   // category bit 7 inverts the sense of the generation bit
   assign gen_flag = ch_sel.category[7] ^ ch_sel.gen_bit;
   assign chstat = ch_sel.pro
      ? {ch_sel.aux_len, 4'hB}
      : {ch_sel.aux_len, 1'b0, ch_sel.audio_n, ch_sel.copy_n, gen_flag};
   // ****************************************
   // emphasis pin
   // ****************************************
   logic       emphasis_r;
   logic       emphasis_nxt;
   // pro streams carry no consumer emphasis, so the pin stays low
   assign emphasis_nxt = ch_sel.pro ? 1'b0 : ch_sel.audio_n;
   always_ff @(posedge core_clk) begin
      if (!resetn)
         emphasis_r <= 1'b0;
      else
         emphasis_r <= emphasis_nxt;
   end
   assign emphasis_pin = emphasis_r;
   // ****************************************
   // receiver error register
   // ****************************************
   logic [6:0] err_in;
   assign err_in = rx_err_src & rxerr_mask_r;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rxerr_r <= 7'h00;
      end else if (rd_err) begin
         rxerr_r <= err_in;
      end else begin
         rxerr_r <= rxerr_r | err_in;
      end
   end
   assign rx_err_out = |rxerr_r;
   // ****************************************
   // read data
   // ****************************************
   logic [7:0] rd_mux;
   always_comb begin
      case (req.addr)
         RSIM_ADDR_MODE_HI: rd_mux = {2'h0, mode_hi_r};
         RSIM_ADDR_MODE_LO: rd_mux = {2'h0, mode_lo_r};
         RSIM_ADDR_IRQ2ST:  rd_mux = {2'h0, irq2_flag};
         RSIM_ADDR_IRQ2MK:  rd_mux = {2'h0, irq2_mask_r};
         RSIM_ADDR_CHSTAT:  rd_mux = chstat;
         RSIM_ADDR_RXERR:   rd_mux = {1'b0, rxerr_r};
         RSIM_ADDR_RXERMK:  rd_mux = {1'b0, rxerr_mask_r};
         RSIM_ADDR_CSCTL:   rd_mux = csctl_r;
         default:           rd_mux = 8'h00;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (!resetn)
         rdata_r <= 8'h00;
      else if (req.rd)
         rdata_r <= rd_mux;
   end
   assign rdata = rdata_r;
   // ****************************************
   // checks
   // ****************************************
   AST_MODE_RESET: assert property (@(posedge core_clk)
      $rose(resetn) |-> (mode_hi_r == 6'h00) && (mode_lo_r == 6'h00))
      else $error("mode regs not zero after reset");
   AST_HI_WRITE: assert property (@(posedge core_clk)
      disable iff (!resetn)
      wr_hi |=> mode_hi_r == $past(req.wdata[5:0]))
      else $error("mode high write lost");
   AST_LO_WRITE: assert property (@(posedge core_clk)
      disable iff (!resetn)
      wr_lo |=> mode_lo_r == $past(req.wdata[5:0]))
      else $error("mode low write lost");
   AST_HI_TOP_ZERO: assert property (@(posedge core_clk)
      disable iff (!resetn)
      (req.rd && req.addr == RSIM_ADDR_MODE_HI) |=> rdata[7:6] == 2'h0)
      else $error("mode bits 7:6 not zero");
   AST_CHSTAT_RO: assert property (@(posedge core_clk)
      disable iff (!resetn)
      (req.wr && req.addr == RSIM_ADDR_CHSTAT)
      |=> $stable(csctl_r) && $stable(mode_hi_r) && $stable(mode_lo_r)
          && $stable(irq2_mask_r) && $stable(rxerr_mask_r))
      else $error("channel status write had effect");
   AST_ERR_MASKED: assert property (@(posedge core_clk)
      disable iff (!resetn)
      (rxerr_mask_r[0] == 1'b0) && $stable(rxerr_mask_r) && !rxerr_r[0]
      |=> !rxerr_r[0])
      else $error("masked error reached register");
   AST_LEVEL_HOLD: assert property (@(posedge core_clk)
      disable iff (!resetn)
      (mode_hi_r[0] && !mode_lo_r[0] && irq2_mask_r[0] && irq2_src[0])
      |=> irq2_flag[0])
      else $error("level flag dropped while present");
   AST_RISE_SET: assert property (@(posedge core_clk)
      disable iff (!resetn)
      (!mode_hi_r[0] && !mode_lo_r[0] && irq2_mask_r[0]
       && $rose(irq2_src[0])) |=> irq2_flag[0] && int_out)
      else $error("rising source missed");
   AST_CHAN_SEL: assert property (@(posedge core_clk)
      disable iff (!resetn)
      csctl_r[RSIM_CHAN_SEL_BIT] |-> chstat[7:4] == chan_b.aux_len)
      else $error("channel b not shown");
   AST_CHAN_A_SEL: assert property (@(posedge core_clk)
      disable iff (!resetn)
      !csctl_r[RSIM_CHAN_SEL_BIT] |-> chstat[7:4] == chan_a.aux_len)
      else $error("channel a not shown");
   // reset forces the delayed source low, so skip the release edge
   AST_FALL_SET: assert property (@(posedge core_clk)
      disable iff (!resetn)
      (!mode_hi_r[3] && mode_lo_r[3] && irq2_mask_r[3] && $past(resetn)
       && $fell(irq2_src[3])) |=> irq2_flag[3])
      else $error("falling source missed");
   AST_LO_TOP_ZERO: assert property (@(posedge core_clk)
      disable iff (!resetn)
      (req.rd && req.addr == RSIM_ADDR_MODE_LO) |=> rdata[7:6] == 2'h0)
      else $error("mode low bits 7:6 not zero");
   // rise and level codes cannot set a flag while the source is low
   AST_READ_CLEAR: assert property (@(posedge core_clk)
      disable iff (!resetn)
      (rd_irq2 && !irq2_src[0] && !mode_lo_r[0]) |=> !irq2_flag[0])
      else $error("status read left a dead flag set");
   AST_RXERR_RO: assert property (@(posedge core_clk)
      disable iff (!resetn)
      (req.wr && req.addr == RSIM_ADDR_RXERR)
      |=> rxerr_r == ($past(rxerr_r) | $past(err_in)))
      else $error("receiver error write had effect");
   AST_RXERR_RELOAD: assert property (@(posedge core_clk)
      disable iff (!resetn)
      rd_err |=> rxerr_r == $past(err_in))
      else $error("error read did not keep live errors only");
endmodule
`default_nettype wire

// >>> rtl/rsim_trig.sv
`default_nettype none
module rsim_trig
   import rsim_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       resetn,
   input  wire logic       src,
   input  wire logic [1:0] code,
   input  wire logic       enable,
   input  wire logic       clr,
   output logic            flag
);
   logic src_d_r;
   logic flag_r;
   logic hit;
   assign hit = enable && (((code == RSIM_TRIG_RISE) && src && !src_d_r)
              || ((code == RSIM_TRIG_FALL) && !src && src_d_r)
              || ((code == RSIM_TRIG_LEVEL) && src));
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         src_d_r <= 1'b0;
         flag_r  <= 1'b0;
      end else begin
         src_d_r <= src;
         // set beats the read clear; level mode stays while present
         if (hit)
            flag_r <= 1'b1;
         else if (clr)
            flag_r <= 1'b0;
      end
   end
   assign flag = flag_r;
endmodule
`default_nettype wire

// >>> test/rsim_host.sv
`default_nettype none
module rsim_host
   import rsim_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic [7:0] rdata,
   output var  rsim_req_t  req
);
   timeunit 1ns;
   timeprecision 1ps;
   initial req = '0;
   // one-cycle strobes, moved only on the falling edge
   task automatic reg_write(input logic [6:0] a, input logic [7:0] d);
      @(negedge core_clk);
      req <= '{rd: 1'h0, wr: 1'h1, addr: a, wdata: d};
      @(negedge core_clk);
      req <= '0;
   endtask
   // read data is registered, so sample one cycle later
   task automatic reg_read(input logic [6:0] a, output logic [7:0] d);
      @(negedge core_clk);
      req <= '{rd: 1'h1, wr: 1'h0, addr: a, wdata: 8'h00};
      @(negedge core_clk);
      req <= '0;
      @(negedge core_clk);
      d = rdata;
   endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
`default_nettype none
module tb_top
   import rsim_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, resetn, int_out, rx_err_out;
   logic [7:0] rdata, d;
   logic [5:0] irq2_src;
   logic [6:0] rx_err_src;
   rsim_chan_t chan_a, chan_b;
   rsim_req_t  req;
   int errors = 0;
   int cmp_count = 0;
   logic       emphasis_pin;
   logic [5:0] sb [3] = '{6'h01, 6'h08, 6'h21};
   logic [7:0] mhi [3] = '{8'h00, 8'h00, 8'h21};
   logic [7:0] mlo [3] = '{8'h00, 8'h08, 8'h00};
   logic [5:0] e1 [3] = '{6'h01, 6'h00, 6'h21};
   logic [5:0] e2 [3] = '{6'h00, 6'h08, 6'h21};
   rsim_regs DUT (.core_clk(core_clk), .resetn(resetn), .req(req),
      .rdata(rdata), .irq2_src(irq2_src), .chan_a(chan_a),
      .chan_b(chan_b), .rx_err_src(rx_err_src), .int_out(int_out),
      .rx_err_out(rx_err_out), .emphasis_pin(emphasis_pin));
   rsim_host host (.core_clk(core_clk), .rdata(rdata), .req(req));
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   // ****************
   // compare and report
   // ****************
   task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chk1(string n, logic e, logic g);
      chk8(n, {7'h00, e}, {7'h00, g});
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #200000;
      errors++;
      finish_test();
   end
   // ****************
   // sequence
   // ****************
   initial begin
      resetn = 1'h0;
      irq2_src = 6'h00;
      rx_err_src = 7'h00;
      chan_a = '{4'h5, 1'h0, 1'h1, 1'h0, 1'h1, 8'h80};
      chan_b = '{4'hA, 1'h0, 1'h0, 1'h1, 1'h1, 8'h01};
      repeat (3) @(negedge core_clk);
      resetn = 1'h1;
      host.reg_read(RSIM_ADDR_MODE_HI, d);
      chk8("mode_hi_rst", 8'h00, d);
      host.reg_read(RSIM_ADDR_MODE_LO, d);
      chk8("mode_lo_rst", 8'h00, d);
      // low bits 5:0 stay clear, so no source ever holds reserved 11
      host.reg_write(RSIM_ADDR_MODE_HI, 8'hFF);
      host.reg_write(RSIM_ADDR_MODE_LO, 8'hC0);
      host.reg_read(RSIM_ADDR_MODE_HI, d);
      chk8("mode_hi_top", 8'h3F, d);
      host.reg_read(RSIM_ADDR_MODE_LO, d);
      chk8("mode_lo_top", 8'h00, d);
      $display("test mode regs done");
      host.reg_read(RSIM_ADDR_CHSTAT, d);
      chk8("chstat_a", 8'h54, d);
      chk1("emphasis_a", 1'h1, emphasis_pin);
      host.reg_write(RSIM_ADDR_CHSTAT, 8'hFF);
      host.reg_read(RSIM_ADDR_CHSTAT, d);
      chk8("chstat_ro", 8'h54, d);
      host.reg_write(RSIM_ADDR_CSCTL, 8'h01);
      host.reg_read(RSIM_ADDR_CHSTAT, d);
      chk8("chstat_b", 8'hA3, d);
      chk1("emphasis_b", 1'h0, emphasis_pin);
      host.reg_write(RSIM_ADDR_CSCTL, 8'h00);
      chan_a.pro = 1'h1;
      host.reg_read(RSIM_ADDR_CHSTAT, d);
      chk8("chstat_pro", 8'h5B, d);
      chk1("emphasis_pro", 1'h0, emphasis_pin);
      $display("test channel status done");
      rx_err_src = 7'h05;
      host.reg_read(RSIM_ADDR_RXERR, d);
      chk8("rxerr_masked", 8'h00, d);
      chk1("rxerr_pin_masked", 1'h0, rx_err_out);
      host.reg_write(RSIM_ADDR_RXERMK, 8'h7F);
      host.reg_write(RSIM_ADDR_RXERR, 8'h00);
      host.reg_read(RSIM_ADDR_RXERR, d);
      chk8("rxerr_set", 8'h05, d);
      chk1("rxerr_pin_set", 1'h1, rx_err_out);
      rx_err_src = 7'h00;
      host.reg_read(RSIM_ADDR_RXERR, d);
      chk8("rxerr_sticky", 8'h05, d);
      host.reg_read(RSIM_ADDR_RXERR, d);
      chk8("rxerr_clr", 8'h00, d);
      chk1("rxerr_pin_clr", 1'h0, rx_err_out);
      $display("test receive errors done");
      host.reg_write(RSIM_ADDR_IRQ2MK, 8'h3F);
      for (int i = 0; i < 3; i++) begin
         host.reg_write(RSIM_ADDR_MODE_HI, mhi[i]);
         host.reg_write(RSIM_ADDR_MODE_LO, mlo[i]);
         host.reg_read(RSIM_ADDR_IRQ2ST, d);
         irq2_src = sb[i];
         repeat (3) @(negedge core_clk);
         chk1("int_on", e1[i] != 6'h00, int_out);
         host.reg_read(RSIM_ADDR_IRQ2ST, d);
         chk8("irq2_on", {2'h0, e1[i]}, d);
         irq2_src = 6'h00;
         repeat (3) @(negedge core_clk);
         host.reg_read(RSIM_ADDR_IRQ2ST, d);
         chk8("irq2_off", {2'h0, e2[i]}, d);
         host.reg_read(RSIM_ADDR_IRQ2ST, d);
         chk8("irq2_clr", 8'h00, d);
         chk1("int_off", 1'h0, int_out);
         $display("test trigger code %0d done", i);
      end
      finish_test();
   end
endmodule
`default_nettype wire
